// ==== brk_map.svh ====
// Register offsets, bit positions and reset values of the breakpoint unit
`ifndef BRK_MAP_SVH
`define BRK_MAP_SVH

// Register offsets
`define BRK_OFS_WAIT_STATUS  16'hFE00
`define BRK_OFS_FLAG_CLR     16'hFE03
`define BRK_OFS_ADDR_HIGH    16'hFE0C
`define BRK_OFS_ADDR_LOW     16'hFE0D
`define BRK_OFS_CTRL_STATUS  16'hFE0E
`define BRK_OFS_IRQ_STATUS   16'hFE10
`define BRK_OFS_IRQ_MASK     16'hFE11

// Bit positions
`define BRK_BIT_MATCH_EN     7
`define BRK_BIT_ACTIVE       6
`define BRK_BIT_WAIT_EXIT    1
`define BRK_BIT_CLR_EN       7
`define BRK_EV_MATCH         0
`define BRK_EV_SOFT          1
`define BRK_EV_WAIT          2

// Event count and values
`define BRK_EV_COUNT         3
`define BRK_BYTE_ZERO        8'h00
`define BRK_EV_ZERO          3'h0
`define BRK_WAIT_FIXED       8'h10

`endif

// ==== brk_pkg.sv ====
// Types shared by the breakpoint unit
package brk_pkg;
	typedef logic [7:0]  byte_t;
	typedef logic [15:0] addr_t;
	typedef logic [2:0]  event_t;
	// One-hot register select
	typedef enum logic [6:0] {
		SEL_NONE   = 7'h00,
		SEL_WAIT   = 7'h01,
		SEL_FLAG   = 7'h02,
		SEL_HIGH   = 7'h04,
		SEL_LOW    = 7'h08,
		SEL_CTRL   = 7'h10,
		SEL_IRQ_ST = 7'h20,
		SEL_IRQ_MK = 7'h40
	} reg_sel_t;
endpackage : brk_pkg

// ==== brk_match_if.sv ====
// Signals between the unit and its address comparator
`timescale 1ns/10ps
interface brk_match_if #(parameter int ADDR_W = 16);
	logic [ADDR_W-1:0] cpu_addr;
	logic [ADDR_W-1:0] bp_addr;
	logic              fetch;
	logic              last;
	logic              enable;
	logic              match;
	logic              match_last;
	modport comparator (
		input  cpu_addr, bp_addr, fetch, last, enable,
		output match, match_last
	);
	modport owner (
		output cpu_addr, bp_addr, fetch, last, enable,
		input  match, match_last
	);
endinterface : brk_match_if

// ==== brk_addr_compare.sv ====
// Registered breakpoint address comparator
`timescale 1ns/10ps
module brk_addr_compare (
	// Clock and reset
	input  wire logic sys_clk_in,
	input  wire logic rst_n_in,
	// Comparator side of the match interface
	brk_match_if.comparator cmp
);
	logic hit;

	// Full-width compare on fetch addresses only
	assign hit = cmp.enable && cmp.fetch &&
		(cmp.cpu_addr == cmp.bp_addr);

	// Match result held one bus clock
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmp.match      <= 1'b0;
			cmp.match_last <= 1'b0;
		end else begin
			cmp.match      <= hit;
			cmp.match_last <= hit && cmp.last;
		end
	end
endmodule : brk_addr_compare

// ==== address_breakpoint_unit.sv ====
// Address breakpoint unit: registers, break request and wait-exit flag
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "brk_map.svh"
module address_breakpoint_unit #(
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	// Register port
	input  wire logic [15:0]       reg_addr_in,
	input  wire logic [7:0]        reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [7:0]        reg_rdata_out,
	// Processor core side
	input  wire logic [ADDR_W-1:0] cpu_addr_in,
	input  wire logic              cpu_fetch_in,
	input  wire logic              cpu_last_cycle_in,
	input  wire logic              cpu_wait_in,
	input  wire logic              cpu_break_state_in,
	output logic                   break_req_out,
	output logic                   break_now_out,
	output logic                   status_clear_allow_out,
	// Interrupt
	output logic                   irq_out
);

	// Width and map checks
	initial begin
		if (ADDR_W != 16) begin
			$error("address_breakpoint_unit: ADDR_W must be 16");
		end
		if (`BRK_EV_COUNT != $bits(brk_pkg::event_t)) begin
			$error("address_breakpoint_unit: event count and type differ");
		end
		if (`BRK_EV_MATCH >= `BRK_EV_COUNT ||
			`BRK_EV_SOFT >= `BRK_EV_COUNT ||
			`BRK_EV_WAIT >= `BRK_EV_COUNT) begin
			$error("address_breakpoint_unit: event bit out of range");
		end
		if (`BRK_BIT_MATCH_EN >= $bits(brk_pkg::byte_t) ||
			`BRK_BIT_ACTIVE >= $bits(brk_pkg::byte_t) ||
			`BRK_BIT_WAIT_EXIT >= $bits(brk_pkg::byte_t) ||
			`BRK_BIT_CLR_EN >= $bits(brk_pkg::byte_t)) begin
			$error("address_breakpoint_unit: flag bit beyond a byte");
		end
	end

	// Set wins over clear for flags cleared by writing zero
	function automatic logic keep_zero_clr(
		input logic cur,
		input logic set,
		input logic wr,
		input logic bit_val
	);
		keep_zero_clr = set | (cur & ~(wr & ~bit_val));
	endfunction : keep_zero_clr

	// Set wins over clear for flags cleared by writing one
	function automatic brk_pkg::event_t w1c(
		input brk_pkg::event_t cur,
		input brk_pkg::event_t set,
		input logic            wr,
		input brk_pkg::event_t wbits
	);
		w1c = set | (cur & ~(wr ? wbits : `BRK_EV_ZERO));
	endfunction : w1c

	// Place one flag into a byte image
	function automatic brk_pkg::byte_t put_bit(
		input brk_pkg::byte_t base,
		input int             pos,
		input logic           val
	);
		put_bit      = base;
		put_bit[pos] = val;
	endfunction : put_bit

	// Register state
	brk_pkg::byte_t   bp_high;
	brk_pkg::byte_t   bp_low;
	logic             match_en;
	logic             active;
	logic             wait_exit;
	logic             clr_en;
	brk_pkg::event_t  irq_status;
	brk_pkg::event_t  irq_mask;
	brk_pkg::byte_t   rdata;
	logic             break_req;
	logic             break_now;
	logic             clear_allow;

	// Next values
	logic             next_active;
	logic             next_wait_exit;
	brk_pkg::event_t  next_irq_status;

	// Decode wires
	brk_pkg::reg_sel_t sel;
	logic              wr_wait;
	logic              wr_flag;
	logic              wr_high;
	logic              wr_low;
	logic              wr_ctrl;
	logic              wr_irq_st;
	logic              wr_irq_mk;
	logic              sw_break;
	logic              break_fire;
	logic              wait_event;
	brk_pkg::event_t   events;
	brk_pkg::byte_t    read_mux;
	logic              allow_now;
	brk_pkg::byte_t    img_wait;
	brk_pkg::byte_t    img_flag;
	brk_pkg::byte_t    img_ctrl;
	logic              irq_pending;

	// Comparator link
	brk_match_if #(.ADDR_W(ADDR_W)) match_link ();

	brk_addr_compare u_compare (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.cmp        (match_link.comparator)
	);

	// Comparator inputs
	assign match_link.cpu_addr = cpu_addr_in;
	assign match_link.bp_addr  = {bp_high, bp_low};
	assign match_link.fetch    = cpu_fetch_in;
	assign match_link.last     = cpu_last_cycle_in;
	assign match_link.enable   = match_en;

	// Address decode into a one-hot select
	always_comb begin
		unique case (reg_addr_in)
			`BRK_OFS_WAIT_STATUS: sel = brk_pkg::SEL_WAIT;
			`BRK_OFS_FLAG_CLR:    sel = brk_pkg::SEL_FLAG;
			`BRK_OFS_ADDR_HIGH:   sel = brk_pkg::SEL_HIGH;
			`BRK_OFS_ADDR_LOW:    sel = brk_pkg::SEL_LOW;
			`BRK_OFS_CTRL_STATUS: sel = brk_pkg::SEL_CTRL;
			`BRK_OFS_IRQ_STATUS:  sel = brk_pkg::SEL_IRQ_ST;
			`BRK_OFS_IRQ_MASK:    sel = brk_pkg::SEL_IRQ_MK;
			default:              sel = brk_pkg::SEL_NONE;
		endcase
	end

	// Write strobes per register
	assign wr_wait   = reg_wr_in && (sel == brk_pkg::SEL_WAIT);
	assign wr_flag   = reg_wr_in && (sel == brk_pkg::SEL_FLAG);
	assign wr_high   = reg_wr_in && (sel == brk_pkg::SEL_HIGH);
	assign wr_low    = reg_wr_in && (sel == brk_pkg::SEL_LOW);
	assign wr_ctrl   = reg_wr_in && (sel == brk_pkg::SEL_CTRL);
	assign wr_irq_st = reg_wr_in && (sel == brk_pkg::SEL_IRQ_ST);
	assign wr_irq_mk = reg_wr_in && (sel == brk_pkg::SEL_IRQ_MK);

	// Software break: a one written to the active flag
	assign sw_break = wr_ctrl && reg_wdata_in[`BRK_BIT_ACTIVE];

	// Any break source this cycle
	assign break_fire = match_link.match | sw_break;

	// Break arriving while the core waits ends the wait
	assign wait_event = break_fire & cpu_wait_in;

	// Event vector for the interrupt status
	assign events[`BRK_EV_MATCH] = match_link.match;
	assign events[`BRK_EV_SOFT]  = sw_break;
	assign events[`BRK_EV_WAIT]  = wait_event;

	// Active flag: match or software sets, write of zero clears
	assign next_active = keep_zero_clr(
		active,
		break_fire,
		wr_ctrl,
		reg_wdata_in[`BRK_BIT_ACTIVE]);

	// Wait-exit flag: break during wait sets, write of zero clears
	assign next_wait_exit = keep_zero_clr(
		wait_exit,
		wait_event,
		wr_wait,
		reg_wdata_in[`BRK_BIT_WAIT_EXIT]);

	// Interrupt status: sticky, write one to clear
	assign next_irq_status = w1c(
		irq_status,
		events,
		wr_irq_st,
		reg_wdata_in[`BRK_EV_COUNT-1:0]);

	// Status clearing allowed outside break state or when enabled
	assign allow_now = ~cpu_break_state_in | clr_en;

	// Read images of the flag registers, reserved bits fixed
	assign img_wait = put_bit(`BRK_WAIT_FIXED, `BRK_BIT_WAIT_EXIT,
		wait_exit);
	assign img_flag = put_bit(`BRK_BYTE_ZERO, `BRK_BIT_CLR_EN,
		clr_en);
	assign img_ctrl = put_bit(put_bit(`BRK_BYTE_ZERO,
		`BRK_BIT_MATCH_EN, match_en), `BRK_BIT_ACTIVE, active);

	// Any unmasked event pending
	assign irq_pending = |(irq_status & irq_mask);

	// Read data selection
	always_comb begin
		read_mux = `BRK_BYTE_ZERO;
		unique case (sel)
			brk_pkg::SEL_WAIT: begin
				read_mux = img_wait;
			end
			brk_pkg::SEL_FLAG: begin
				read_mux = img_flag;
			end
			brk_pkg::SEL_HIGH: begin
				read_mux = bp_high;
			end
			brk_pkg::SEL_LOW: begin
				read_mux = bp_low;
			end
			brk_pkg::SEL_CTRL: begin
				read_mux = img_ctrl;
			end
			brk_pkg::SEL_IRQ_ST: begin
				read_mux[`BRK_EV_COUNT-1:0] = irq_status;
			end
			brk_pkg::SEL_IRQ_MK: begin
				read_mux[`BRK_EV_COUNT-1:0] = irq_mask;
			end
			brk_pkg::SEL_NONE: begin
				read_mux = `BRK_BYTE_ZERO;
			end
			default: begin
				read_mux = `BRK_BYTE_ZERO;
			end
		endcase
	end

	// Breakpoint address bytes
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bp_high <= `BRK_BYTE_ZERO;
			bp_low  <= `BRK_BYTE_ZERO;
		end else begin
			if (wr_high) begin
				bp_high <= reg_wdata_in;
			end
			if (wr_low) begin
				bp_low <= reg_wdata_in;
			end
		end
	end

	// Match enable and clear enable controls
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			match_en <= 1'b0;
			clr_en   <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				match_en <= reg_wdata_in[`BRK_BIT_MATCH_EN];
			end
			if (wr_flag) begin
				clr_en <= reg_wdata_in[`BRK_BIT_CLR_EN];
			end
		end
	end

	// Status flags
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active    <= 1'b0;
			wait_exit <= 1'b0;
		end else begin
			active    <= next_active;
			wait_exit <= next_wait_exit;
		end
	end

	// Interrupt status and mask
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			irq_status <= `BRK_EV_ZERO;
			irq_mask   <= `BRK_EV_ZERO;
		end else begin
			irq_status <= next_irq_status;
			if (wr_irq_mk) begin
				irq_mask <= reg_wdata_in[`BRK_EV_COUNT-1:0];
			end
		end
	end

	// Break request and immediate-start pulses
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			break_req <= 1'b0;
			break_now <= 1'b0;
		end else begin
			break_req <= break_fire;
			break_now <= match_link.match_last;
		end
	end

	// Clear permission towards other status registers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clear_allow <= 1'b1;
		end else begin
			clear_allow <= allow_now;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata <= `BRK_BYTE_ZERO;
		end else begin
			rdata <= reg_rd_in ? read_mux : `BRK_BYTE_ZERO;
		end
	end

	// Outputs
	assign reg_rdata_out          = rdata;
	assign break_req_out          = break_req;
	assign break_now_out          = break_now;
	assign status_clear_allow_out = clear_allow;
	assign irq_out                = irq_pending;

endmodule : address_breakpoint_unit

// ==== address_breakpoint_unit_chk.sv ====
// Port checker of the address breakpoint unit
`timescale 1ns/10ps
module brk_unit_chk (
	// Clock, reset and register port
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic [15:0] reg_addr_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	// Core side
	input wire logic        cpu_fetch_in,
	input wire logic        cpu_last_cycle_in,
	input wire logic        cpu_break_state_in,
	input wire logic        break_req_out,
	input wire logic        break_now_out,
	input wire logic        status_clear_allow_out
);
	logic sw;
	// Software break write
	assign sw = reg_wr_in && reg_addr_in == 16'hFE0E && reg_wdata_in[6];
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	sequence s_sw;
		sw;
	endsequence
	sequence s_rd(a);
		reg_rd_in && reg_addr_in == a;
	endsequence
	AST_SW_REQ: assert property (s_sw |=> break_req_out)
		else $error("soft break gave no request");
	AST_REQ_SRC: assert property (break_req_out && !$past(sw)
		|-> $past(cpu_fetch_in, 2)) else $error("request without fetch");
	AST_NOW_REQ: assert property (break_now_out
		|-> break_req_out && $past(cpu_last_cycle_in, 2))
		else $error("immediate break out of place");
	AST_RD_IDLE: assert property (!$past(reg_rd_in)
		|-> reg_rdata_out == 8'h00) else $error("read data not idle");
	AST_WAIT_RSV: assert property (s_rd(16'hFE00)
		|=> (reg_rdata_out & 8'hFD) == 8'h10) else $error("wait status bits");
	AST_CTRL_RSV: assert property (s_rd(16'hFE0E)
		|=> reg_rdata_out[5:0] == 6'h00) else $error("control spare bits");
	AST_FLAG_RSV: assert property (s_rd(16'hFE03)
		|=> reg_rdata_out[6:0] == 7'h00) else $error("clear control bits");
	AST_ALLOW_LOCK: assert property (!status_clear_allow_out
		|-> $past(cpu_break_state_in)) else $error("clear locked outside");
endmodule : brk_unit_chk

bind address_breakpoint_unit brk_unit_chk i_brk_unit_chk (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
	.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .cpu_fetch_in(cpu_fetch_in),
	.cpu_last_cycle_in(cpu_last_cycle_in),
	.cpu_break_state_in(cpu_break_state_in),
	.break_req_out(break_req_out), .break_now_out(break_now_out),
	.status_clear_allow_out(status_clear_allow_out)
);

// ==== brk_core_model.sv ====
// Behavioural processor core facing the breakpoint unit
`timescale 1ns/10ps
module brk_core_model (
	// Clock, reset and bench commands
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [15:0] pc_in,
	input  wire logic        go_in,
	input  wire logic        last_in,
	input  wire logic        wait_in,
	input  wire logic        rti_in,
	// Unit side
	input  wire logic        break_req_in,
	output logic      [15:0] addr_out,
	output logic             fetch_out,
	output logic             last_out,
	output logic             wait_out,
	output logic             brk_state_out
);
	// Fetch stream, wait and break state
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			addr_out      <= 16'h0000;
			fetch_out     <= 1'b0;
			last_out      <= 1'b0;
			wait_out      <= 1'b0;
			brk_state_out <= 1'b0;
		end else begin
			addr_out      <= go_in ? pc_in : ~addr_out; // Idle bus toggles
			fetch_out     <= go_in && !brk_state_out;
			last_out      <= go_in && last_in;
			wait_out      <= wait_in && !brk_state_out && !break_req_in;
			brk_state_out <= break_req_in || (brk_state_out && !rti_in);
		end
	end
endmodule : brk_core_model

// ==== tb.sv ====
// Self-checking bench of the address breakpoint unit
`timescale 1ns/10ps
module tb;
	logic        sys_clk_in, rst_n_in, wr, rd, go, last, wt, rti;
	logic [15:0] addr, pc;
	logic [7:0]  wdata;
	wire  [7:0]  rdata;
	wire  [15:0] c_addr;
	wire         c_fetch, c_last, c_wait, c_brk, req, now, allow, irq;
	int          error_cnt, samples_checked, cyc;
	// Address, write data, read after write, reset value
	logic [39:0] rows [8] = '{40'hFE0C_5A_5A_00, 40'hFE0D_A5_A5_00,
		40'hFE00_FF_10_10, 40'hFE03_FF_80_00, 40'hFE0E_80_80_00,
		40'hFE11_07_07_00, 40'hFE10_07_00_00, 40'hFE05_AA_00_00};
	address_breakpoint_unit i_address_breakpoint_unit (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .cpu_addr_in(c_addr),
		.cpu_fetch_in(c_fetch), .cpu_last_cycle_in(c_last),
		.cpu_wait_in(c_wait), .cpu_break_state_in(c_brk),
		.break_req_out(req), .break_now_out(now),
		.status_clear_allow_out(allow), .irq_out(irq));
	brk_core_model i_brk_core_model (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .pc_in(pc),
		.go_in(go), .last_in(last), .wait_in(wt), .rti_in(rti),
		.break_req_in(req), .addr_out(c_addr), .fetch_out(c_fetch),
		.last_out(c_last), .wait_out(c_wait), .brk_state_out(c_brk));
	// Clock
	initial begin
		sys_clk_in = 1'b0;
		forever #2 sys_clk_in = ~sys_clk_in;
	end
	task automatic test_done;
		if (error_cnt == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// One register cycle, write or read
	task automatic bus(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge sys_clk_in);
		wr    <= w;
		rd    <= !w;
		addr  <= a;
		wdata <= d;
		@(posedge sys_clk_in);
		wr    <= 1'b0;
		rd    <= 1'b0;
		#1;
	endtask : bus
	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rdata, e);
	endtask : rdc
	// One fetch cycle of the core
	task automatic cpu(input logic [15:0] a, input logic l);
		@(posedge sys_clk_in);
		pc   <= a;
		go   <= 1'b1;
		last <= l;
		@(posedge sys_clk_in);
		go   <= 1'b0;
	endtask : cpu
	// Collect request and immediate flags over eight cycles
	task automatic waitreq(input logic [7:0] e);
		logic [7:0] s = 8'h00;
		repeat (8) begin
			#1;
			s = s | {6'h00, req, now};
			@(posedge sys_clk_in);
		end
		chk(s, e);
	endtask : waitreq
	// Hang guard
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			test_done;
		end
	end
	initial begin
		{rst_n_in, wr, rd, go, last, wt, rti} = 7'h00;
		{addr, pc, wdata} = 40'h0;
		repeat (3) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		foreach (rows[i])
			rdc(rows[i][39:24], rows[i][7:0]);
		foreach (rows[i]) begin
			bus(1'b1, rows[i][39:24], rows[i][23:16]);
			rdc(rows[i][39:24], rows[i][15:8]);
		end
		bus(1'b1, 16'hFE03, 8'h00);
		cpu(16'h5AA5, 1'b1);
		waitreq(8'h03);
		rdc(16'hFE0E, 8'hC0);
		chk({7'h00, irq}, 8'h01);
		chk({7'h00, allow}, 8'h00);
		cpu(16'h5AA5, 1'b0);
		waitreq(8'h00);
		bus(1'b1, 16'hFE03, 8'h80);
		rdc(16'hFE03, 8'h80);
		chk({7'h00, allow}, 8'h01);
		bus(1'b1, 16'hFE0E, 8'h80);
		rdc(16'hFE0E, 8'h80);
		bus(1'b1, 16'hFE10, 8'h07);
		chk({7'h00, irq}, 8'h00);
		rti <= 1'b1;
		bus(1'b1, 16'hFE0E, 8'h00);
		rti <= 1'b0;
		cpu(16'h5AA5, 1'b0);
		waitreq(8'h00);
		bus(1'b1, 16'hFE0E, 8'h80);
		cpu(16'h5AA4, 1'b0);
		waitreq(8'h00);
		wt <= 1'b1;
		bus(1'b1, 16'hFE11, 8'h00);
		bus(1'b1, 16'hFE0E, 8'hC0);
		waitreq(8'h02);
		rdc(16'hFE00, 8'h12);
		chk({7'h00, irq}, 8'h00);
		bus(1'b1, 16'hFE11, 8'h04);
		chk({7'h00, irq}, 8'h01);
		bus(1'b1, 16'hFE10, 8'h06);
		chk({7'h00, irq}, 8'h00);
		bus(1'b1, 16'hFE00, 8'h00);
		rdc(16'hFE00, 8'h10);
		test_done;
	end
endmodule : tb
